// ### include/eeprom_pkg.sv
// Constants and the carrier type for the two-wire serial memory
package eeprom_pkg;
    localparam int          MEM_DEPTH      = 2048;
    localparam int          ADDR_W         = 11;
    localparam int          PAGE_BYTES     = 16;
    localparam int          PAGE_W         = 4;
    localparam logic [3:0]  DEV_TYPE_CODE  = 4'h5;   // Arbitrary value
    localparam int          TYPE_HI        = 7;
    localparam int          TYPE_LO        = 4;
    localparam int          UPADDR_HI      = 3;
    localparam int          UPADDR_LO      = 1;
    localparam int          RW_BIT         = 0;
    localparam int          CLK_MHZ        = 125;
    localparam int          WRITE_TIME_US  = 5000;
    localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
    localparam int          FIFO_DEPTH     = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } wr_word_s;
endpackage

// ### verilog/wr_fifo.sv
// Small synchronous FIFO for pending page-write words
`timescale 1ns/100ps
module wr_fifo
#(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
)
(
    // Clock and control
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_flush,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data  = mem_reg[rp_reg];

    always_comb
    begin
        push     = i_in_valid && o_in_ready;
        pop      = o_out_valid && i_out_ready;
        wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = (AW+1)'(cnt_reg + {AW'(0), push} - {AW'(0), pop});
        if (i_flush)
        begin
            wp_next  = '0;
            rp_next  = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else if (i_ce)
        begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            if (push && !i_flush)
                mem_reg[wp_reg] <= i_in_data;
        end
    end

    a_fifo_no_overflow : assert property (@(posedge i_core_clk) disable iff (i_rst)
        cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ### verilog/serial_eeprom.sv
// Two-wire serial memory slave with page write, reads and write protect
`timescale 1ns/100ps
module serial_eeprom
    import eeprom_pkg::*;
#(
    parameter int  WRITE_CNT = WRITE_CYCLES,
    parameter bit  HAS_WP    = 1'b1
)
(
    // Clock, reset, enable
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Serial pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_o,
    output logic      o_sda_oe,
    // Write protect, pulled low outside when floating
    input  wire logic i_wp,
    // Status
    output logic      o_busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_WADR = 3'b011,
        ST_WDAT = 3'b010,
        ST_RDAT = 3'b110,
        ST_ACK  = 3'b111,
        ST_RACK = 3'b101,
        ST_SKIP = 3'b100
    } state_e;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_s_reg, sda_s_reg, wp_s_reg;
    logic       scl_d_reg, sda_d_reg;
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            scl_s_reg <= 2'h3;
            sda_s_reg <= 2'h3;
            wp_s_reg  <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else if (i_ce)
        begin
            scl_s_reg <= {scl_s_reg[0], i_scl};
            sda_s_reg <= {sda_s_reg[0], i_sda};
            wp_s_reg  <= {wp_s_reg[0], i_wp};
            scl_d_reg <= scl_s_reg[1];
            sda_d_reg <= sda_s_reg[1];
        end
    end
    // Oversampling keeps up with the fastest serial clock
    wire scl    = scl_s_reg[1];
    wire sda    = sda_s_reg[1];
    wire scl_rise = scl && !scl_d_reg;
    wire scl_fall = !scl && scl_d_reg;
    wire start_c  = scl && scl_d_reg && sda_d_reg && !sda;
    wire stop_c   = scl && scl_d_reg && !sda_d_reg && sda;
    wire protect  = HAS_WP && wp_s_reg[1];

    // ------------------------------------------------------------
    // Array and write path
    // ------------------------------------------------------------
    logic [7:0]        mem [MEM_DEPTH];
    wr_word_s          fin, fout;
    logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
    wr_fifo #(.WIDTH($bits(wr_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_flush     (f_flush),
        .i_in_valid  (f_in_valid),
        .o_in_ready  (f_in_ready),
        .i_in_data   (fin),
        .o_out_valid (f_out_valid),
        .i_out_ready (f_out_ready),
        .o_out_data  (fout)
    );

    // ------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------
    state_e            st_reg, st_next, ret_reg, ret_next;
    logic [3:0]        bit_reg, bit_next;
    logic [7:0]        sh_reg, sh_next;
    logic [ADDR_W-1:0] ptr_reg, ptr_next;
    logic              rw_reg, rw_next;
    logic              ackd_reg, ackd_next;
    logic              sda_oe_reg, sda_oe_next;
    logic              pend_reg, pend_next;
    logic [31:0]       tmr_reg, tmr_next;
    logic              busy_reg, busy_next;
    logic [PAGE_W:0]   pcnt_reg, pcnt_next;
    // Page staging buffer, filled from the FIFO, committed when busy
    logic [7:0]              page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]   pmask_reg, pmask_next;
    logic [ADDR_W-PAGE_W-1:0] pbase_reg, pbase_next;

    always_comb
    begin
        st_next     = st_reg;
        ret_next    = ret_reg;
        bit_next    = bit_reg;
        sh_next     = sh_reg;
        ptr_next    = ptr_reg;
        rw_next     = rw_reg;
        ackd_next   = ackd_reg;
        sda_oe_next = sda_oe_reg;
        pend_next   = pend_reg;
        tmr_next    = tmr_reg;
        busy_next   = busy_reg;
        pcnt_next   = pcnt_reg;
        pmask_next  = pmask_reg;
        pbase_next  = pbase_reg;
        f_in_valid  = 1'b0;
        f_flush     = 1'b0;
        fin.addr    = ptr_reg;
        fin.data    = sh_reg;
        // The FIFO drains every cycle; self-timed programming counts out once it is empty
        f_out_ready = 1'b1;
        if (f_out_valid)
        begin
            pmask_next[fout.addr[PAGE_W-1:0]] = 1'b1;
            pbase_next = fout.addr[ADDR_W-1:PAGE_W];
        end
        if (busy_reg && !f_out_valid)
        begin
            pmask_next = '0;
            if (tmr_reg >= 32'(WRITE_CNT - 1))
                busy_next = 1'b0;
            else
                tmr_next = tmr_reg + 32'h1;
        end
        case (st_reg)
            ST_IDLE, ST_SKIP: sda_oe_next = 1'b0;
            ST_DEV, ST_WADR, ST_WDAT:
            begin
                if (scl_rise)
                begin
                    sh_next  = {sh_reg[6:0], sda};
                    bit_next = bit_reg + 4'h1;
                end
                if (scl_fall && bit_reg == 4'h8)
                begin
                    bit_next = 4'h0;
                    st_next  = ST_ACK;
                    ret_next = st_reg;
                    ackd_next = 1'b1;
                    if (st_reg == ST_DEV)
                    begin
                        if (sh_reg[TYPE_HI:TYPE_LO] != DEV_TYPE_CODE || busy_reg)
                        begin
                            ackd_next = 1'b0;
                            st_next   = ST_SKIP;
                        end
                        else
                        begin
                            rw_next = sh_reg[RW_BIT];
                            ptr_next[ADDR_W-1:8] = sh_reg[UPADDR_HI:UPADDR_LO];
                            sda_oe_next = 1'b1;
                        end
                    end
                    else if (st_reg == ST_WADR)
                    begin
                        ptr_next[7:0] = sh_reg;
                        pcnt_next   = '0;
                        sda_oe_next = 1'b1;
                    end
                    else
                    begin
                        if (pcnt_reg < (PAGE_W+1)'(PAGE_BYTES) && f_in_ready)
                        begin
                            f_in_valid = !protect;
                            pend_next  = pend_reg | !protect;
                            pcnt_next  = pcnt_reg + 1'b1;
                        end
                        ptr_next[PAGE_W-1:0] = ptr_reg[PAGE_W-1:0] + 1'b1;
                        sda_oe_next = 1'b1;
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    sda_oe_next = 1'b0;
                    if (ret_reg == ST_DEV && rw_reg)
                    begin
                        st_next     = ST_RDAT;
                        sh_next     = mem[ptr_reg];
                        sda_oe_next = !mem[ptr_reg][7];
                    end
                    else
                        st_next = (ret_reg == ST_DEV) ? ST_WADR : ST_WDAT;
                end
            end
            ST_RDAT:
            begin
                if (scl_fall)
                begin
                    bit_next = bit_reg + 4'h1;
                    if (bit_reg == 4'h7)
                    begin
                        sda_oe_next = 1'b0;
                        st_next     = ST_RACK;
                        ptr_next    = ADDR_W'(ptr_reg + 1'b1);
                    end
                    else
                    begin
                        sh_next     = {sh_reg[6:0], 1'b0};
                        sda_oe_next = !sh_reg[6];
                    end
                end
            end
            ST_RACK:
            begin
                if (scl_rise)
                    ackd_next = !sda;
                if (scl_fall)
                begin
                    bit_next = 4'h0;
                    if (ackd_reg)
                    begin
                        st_next     = ST_RDAT;
                        sh_next     = mem[ptr_reg];
                        sda_oe_next = !mem[ptr_reg][7];
                    end
                    else
                        st_next = ST_SKIP;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (start_c)
        begin
            st_next     = ST_DEV;
            bit_next    = 4'h0;
            sda_oe_next = 1'b0;
            if (pend_reg)
            begin
                f_flush    = 1'b1;
                pend_next  = 1'b0;
                pmask_next = '0;
            end
        end
        else if (stop_c)
        begin
            st_next     = ST_IDLE;
            sda_oe_next = 1'b0;
            if (pend_reg)
            begin
                busy_next = 1'b1;
                tmr_next  = '0;
                pend_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            st_reg     <= ST_IDLE;
            ret_reg    <= ST_IDLE;
            bit_reg    <= 4'h0;
            sh_reg     <= 8'h00;
            ptr_reg    <= '0;
            rw_reg     <= 1'b0;
            ackd_reg   <= 1'b0;
            sda_oe_reg <= 1'b0;
            pend_reg   <= 1'b0;
            tmr_reg    <= 32'h0;
            busy_reg   <= 1'b0;
            pcnt_reg   <= '0;
            pmask_reg  <= '0;
            pbase_reg  <= '0;
        end
        else if (i_ce)
        begin
            st_reg     <= st_next;
            ret_reg    <= ret_next;
            bit_reg    <= bit_next;
            sh_reg     <= sh_next;
            ptr_reg    <= ptr_next;
            rw_reg     <= rw_next;
            ackd_reg   <= ackd_next;
            sda_oe_reg <= sda_oe_next;
            pend_reg   <= pend_next;
            tmr_reg    <= tmr_next;
            busy_reg   <= busy_next;
            pcnt_reg   <= pcnt_next;
            pmask_reg  <= pmask_next;
            pbase_reg  <= pbase_next;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_ce && f_out_valid)
            page_buf[fout.addr[PAGE_W-1:0]] <= fout.data;
        if (i_ce && busy_reg && !f_out_valid)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (pmask_reg[i])
                    mem[{pbase_reg, PAGE_W'(i)}] <= page_buf[i];
            end
        end
    end

    assign o_sda_o  = 1'b0;
    assign o_sda_oe = sda_oe_reg;
    assign o_busy   = busy_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sda_change_fall : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && $changed(sda_oe_reg) && $past(st_reg) == ST_RDAT && !$past(start_c) && !$past(stop_c))
        |-> $past(scl_fall)) else $error("read data moved off falling edge");
    a_sda_low_only : assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_sda_o == 1'b0) else $error("data line driven high");
    a_start_to_dev : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && start_c) |=> st_reg == ST_DEV) else $error("start missed");
    a_stop_to_idle : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && stop_c) |=> st_reg == ST_IDLE && !sda_oe_reg) else $error("stop missed");
    a_bad_type_nack : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && st_reg == ST_DEV && scl_fall && bit_reg == 4'h8 && !start_c && !stop_c
         && sh_reg[TYPE_HI:TYPE_LO] != DEV_TYPE_CODE) |=> st_reg == ST_SKIP && !sda_oe_reg)
        else $error("bad type acknowledged");
    a_protect_blocks : assert property (@(posedge i_core_clk) disable iff (i_rst)
        protect |-> !f_in_valid) else $error("write queued while protected");
    a_page_limit : assert property (@(posedge i_core_clk) disable iff (i_rst)
        pcnt_reg <= (PAGE_W+1)'(PAGE_BYTES)) else $error("page overrun");
    a_busy_start : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && stop_c && pend_reg) |=> busy_reg && tmr_reg == 32'h0) else $error("write not started");
    a_sample_rise : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && st_reg == ST_WADR && scl_rise && !start_c && !stop_c) |=> sh_reg[0] == $past(sda))
        else $error("bit not sampled");
    c_write : cover property (@(posedge i_core_clk) busy_reg && f_out_valid);
    c_read  : cover property (@(posedge i_core_clk) st_reg == ST_RDAT && scl_fall);
    c_seq   : cover property (@(posedge i_core_clk) st_reg == ST_RACK && ackd_reg && scl_fall);
    c_nack  : cover property (@(posedge i_core_clk) st_next == ST_SKIP);
endmodule

// ### sim/i2c_master_model.sv
// Bus master model driving the serial clock and the data line
`timescale 1ns/100ps
module i2c_master_model
(
    // Clock
    input  wire logic i_core_clk,
    // Serial pins
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    // Start or repeated start
    task automatic start_cond;
        o_sda_low <= 1'b0;
        cyc(5);
        o_scl <= 1'b1;
        cyc(10);
        o_sda_low <= 1'b1;
        cyc(10);
        o_scl <= 1'b0;
        cyc(5);
    endtask

    // Stop, clock left high
    task automatic stop_cond;
        o_sda_low <= 1'b1;
        cyc(5);
        o_scl <= 1'b1;
        cyc(10);
        o_sda_low <= 1'b0;
        cyc(10);
    endtask

    // One bit: data set in low phase, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic s);
        o_sda_low <= ~b;
        cyc(5);
        o_scl <= 1'b1;
        cyc(5);
        @(negedge i_core_clk);
        s = i_sda;
        cyc(5);
        o_scl <= 1'b0;
        cyc(5);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++)
        begin
            bit_xfer(1'b1, s);
            d = {d[6:0], s};
        end
        bit_xfer(~ack_it, s);
    endtask
endmodule

// ### sim/serial_eeprom_bus_pins_wp_tb.sv
// Self-checking bench for the two-wire serial memory
`timescale 1ns/100ps
module serial_eeprom_bus_pins_wp_tb import eeprom_pkg::*;;
    localparam int WCNT = 600;
    logic i_core_clk;
    logic i_rst;
    logic i_ce;
    logic i_wp;
    logic scl;
    logic m_low;
    logic sda_wire;
    logic o_sda_o;
    logic o_sda_oe;
    logic o_busy;
    logic scl_q;
    logic oe_q;
    int   bad_count;
    int   checks_done;

    assign sda_wire = ~(o_sda_oe | m_low);

    serial_eeprom #(.WRITE_CNT(WCNT), .HAS_WP(1'b1)) i_serial_eeprom
    (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_scl      (scl),
        .i_sda      (sda_wire),
        .o_sda_o    (o_sda_o),
        .o_sda_oe   (o_sda_oe),
        .i_wp       (i_wp),
        .o_busy     (o_busy)
    );

    i2c_master_model i_i2c_master_model
    (
        .i_core_clk (i_core_clk),
        .i_sda      (sda_wire),
        .o_scl      (scl),
        .o_sda_low  (m_low)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Pin monitor, sampled at the falling core edge
    always @(negedge i_core_clk)
    begin
        scl_q <= scl;
        oe_q  <= o_sda_oe;
        if (!i_rst && scl_q && scl)
            check({7'h0, o_sda_oe}, {7'h0, oe_q}, "data moved in clock high");
        if (o_sda_oe)
            check({7'h0, o_sda_o}, 8'h00, "data driven high");
    end

    task automatic send(input logic [7:0] d, input logic exp_ack, input string msg);
        logic ack;
        i_i2c_master_model.send_byte(d, ack);
        check({7'h0, ack}, {7'h0, exp_ack}, msg);
    endtask

    task automatic do_write(input logic [10:0] a, input int n, input logic [7:0] base);
        i_i2c_master_model.start_cond();
        send({DEV_TYPE_CODE, a[10:8], 1'b0}, 1'b1, "device write ack");
        send(a[7:0], 1'b1, "word address ack");
        for (int i = 0; i < n; i++)
        begin
            send(base + 8'(i), 1'b1, "data ack");
        end
        i_i2c_master_model.stop_cond();
    endtask

    task automatic do_read(input logic [10:0] a, input int n, input logic [7:0] base);
        logic [7:0] d;
        i_i2c_master_model.start_cond();
        send({DEV_TYPE_CODE, a[10:8], 1'b0}, 1'b1, "device write ack");
        send(a[7:0], 1'b1, "word address ack");
        i_i2c_master_model.start_cond();
        send({DEV_TYPE_CODE, a[10:8], 1'b1}, 1'b1, "device read ack");
        for (int i = 0; i < n; i++)
        begin
            i_i2c_master_model.recv_byte(i < n - 1, d);
            check(d, base + 8'(i), "read data");
        end
        i_i2c_master_model.stop_cond();
    endtask

    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < lim)
        begin
            @(posedge i_core_clk);
            k++;
        end
        check({7'h0, o_busy}, 8'h00, "write cycle too long");
    endtask

    // Full page at a page start with the upper address bits at 3'h3
    task automatic t_page_write;
        do_write(11'h3f0, 16, 8'ha0);
        repeat (4) @(posedge i_core_clk);
        check({7'h0, o_busy}, 8'h01, "self-timed write not started");
        i_i2c_master_model.start_cond();
        send({DEV_TYPE_CODE, 3'h3, 1'b0}, 1'b0, "ack while busy");
        i_i2c_master_model.stop_cond();
        wait_idle(WCNT + 2000);
        do_read(11'h3f0, 16, 8'ha0);
        do_write(11'h7fe, 2, 8'h5c);
        wait_idle(WCNT + 2000);
        do_read(11'h7fe, 2, 8'h5c);
        $display("test page write done");
    endtask

    // Protected write is acknowledged but leaves the array alone
    task automatic t_protect;
        i_wp <= 1'b1;
        do_write(11'h3f4, 3, 8'h11);
        wait_idle(WCNT + 2000);
        i_wp <= 1'b0;
        do_read(11'h3f4, 3, 8'ha4);
        $display("test protect done");
    endtask

    // Foreign type code refused, device back in standby
    task automatic t_bad_type;
        i_i2c_master_model.start_cond();
        send({DEV_TYPE_CODE ^ 4'h1, 3'h3, 1'b1}, 1'b0, "foreign code acked");
        i_i2c_master_model.stop_cond();
        do_read(11'h3f0, 1, 8'ha0);
        $display("test bad type done");
    endtask

    initial
    begin
        i_rst       = 1'b1;
        i_ce        = 1'b1;
        i_wp        = 1'b0;
        bad_count   = 0;
        checks_done = 0;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        t_page_write();
        t_protect();
        t_bad_type();
        summarize();
    end

    // Watchdog
    initial
    begin
        #400000;
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
